/* dv/fault_stage_model.sv */
// Model of the fault sources that sit beyond the shutdown block
module fault_stage_model (
  // Trip requests from the bench, one bit per source
  input wire [2:0] trip,
  // Source lines toward the block
  output wire comparator_async_out,
  output wire logic_cell_two_out,
  output wire fault_input_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Source levels; the pin is wired low-active like a real fault line
  assign comparator_async_out = trip[2];
  assign fault_input_pin_n = ~trip[1];
  assign logic_cell_two_out = trip[0];
endmodule // fault_stage_model

/* dv/waveform_auto_shutdown_props.sv */
// Concurrent checks on the ports of the auto-shutdown block
module waveform_auto_shutdown_props (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Levels and sources
  input wire override_level_a,
  input wire override_level_b,
  input wire comparator_async_out,
  input wire logic_cell_two_out,
  input wire fault_input_pin_n,
  input wire out_a,
  input wire out_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en;
  logic hold;
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire ctl_rd = take & ~wb_we_i & (wb_adr_i == 8'h00);
  wire ctl_wr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00);
  wire src = (en[2] & comparator_async_out) | (en[1] & ~fault_input_pin_n)
    | (en[0] & logic_cell_two_out);
  wire ovr = (out_a == override_level_a) & (out_b == override_level_b);
  // ============================================================
  // Shadow of the control bits; hold marks a shutdown that cannot self-clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      en <= 8'h00;
      hold <= 1'b0;
    end else begin
      if (ctl_wr) en <= wb_dat_i[7:0];
      if (src & ~(ctl_wr ? wb_dat_i[6] : en[6])) hold <= 1'b1;
      else if (ctl_wr) hold <= wb_dat_i[7] & ~wb_dat_i[6];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_reserved_zero: assert property (
    ctl_rd |=> wb_dat_o[5:3] == 3'b000) else $error("reserved bits set");
  a_enables_readback: assert property (
    ctl_rd |=> wb_dat_o[2:0] == en[2:0]) else $error("enables read wrong");
  a_flag_reads_set: assert property (
    ctl_rd & hold |=> wb_dat_o[7]) else $error("event flag reads clear");
  a_comparator_force: assert property (
    en[2] & comparator_async_out |-> ovr) else $error("comparator ignored");
  a_pin_force: assert property (
    en[1] & ~fault_input_pin_n |-> ovr) else $error("fault pin ignored");
  a_cell_force: assert property (
    en[0] & logic_cell_two_out |-> ovr) else $error("logic cell ignored");
  a_held_override: assert property (
    hold |-> ovr) else $error("held shutdown released");
endmodule // waveform_auto_shutdown_props
bind waveform_auto_shutdown waveform_auto_shutdown_props
  waveform_auto_shutdown_props_inst (.*);

/* dv/waveform_auto_shutdown_tb_top.sv */
// Self-checking bench for the auto-shutdown block
module waveform_auto_shutdown_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic wave_in, override_level_a, override_level_b, out_a, out_b;
  logic comparator_async_out, logic_cell_two_out, fault_input_pin_n;
  logic [7:0] wb_adr_i, d;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, band;
  logic [2:0] trip;
  int n_mismatch, check_count, seed, i, j;
  waveform_auto_shutdown waveform_auto_shutdown_inst (.*);
  fault_stage_model fault_stage_model_inst (.trip(trip),
    .comparator_async_out(comparator_async_out),
    .logic_cell_two_out(logic_cell_two_out),
    .fault_input_pin_n(fault_input_pin_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ============================================================
  // Expected control read: flag, restart bit, zeros, enables
  function automatic logic [31:0] ctl_read(input logic f, input logic [7:0] w);
    return {24'h0, f, w[6], 3'b000, w[2:0]};
  endfunction
  // Output level k clocks after an input edge, for a count of n
  function automatic logic db_on(input int k, input int n);
    return k >= n + 2; // One clock of sampling, one of the drive flop, then n
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One classic cycle; entered just after a rising edge
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] v);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 40) chk(1'b0, 1'b1, "no ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  // A rising then falling input, long enough for the edge logic
  task automatic pulse_wave;
    wave_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wave_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h0ed50d71;
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wave_in, trip} = 0;
    {wb_adr_i, wb_dat_i} = 0;
    wb_sel_i = 4'hf;
    override_level_a = 1'b1;
    override_level_b = 1'b1;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 8'h00, 0);
    chk(rd, 0, "control reset");
    // Random control values with no source active
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[7] = 1'b0;
      bus(1'b1, 8'h00, d);
      bus(1'b0, 8'h00, 0);
      chk(rd, ctl_read(1'b0, d), "control readback");
    end
    // Each source: ignored when disabled, forcing and level-held when on
    for (i = 0; i < 3; i++) begin
      d = 8'h01 << i;
      bus(1'b1, 8'h00, 8'h07 & ~d);
      trip <= d[2:0];
      repeat (3) @(posedge clk_sys);
      chk(out_a, 1'b0, "disabled source");
      trip <= 3'b000;
      override_level_b <= 1'($random(seed));
      bus(1'b1, 8'h00, 8'h07);
      trip <= d[2:0];
      @(negedge clk_sys);
      chk({out_a, out_b}, {1'b1, override_level_b}, "instant");
      @(posedge clk_sys);
      bus(1'b1, 8'h00, 8'h07);
      bus(1'b0, 8'h00, 0);
      chk(rd, ctl_read(1'b1, 8'h07), "level source");
      trip <= 3'b000;
      repeat (5) @(posedge clk_sys);
      chk({out_a, out_b}, {1'b1, override_level_b}, "held");
      bus(1'b1, 8'h00, 8'h07);
      repeat (4) @(posedge clk_sys);
      chk(out_a, 1'b0, "released");
    end
    // Software shutdown cleared by the next input rise
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 8'hc0);
    repeat (3) @(posedge clk_sys);
    chk({out_a, irq}, 2'b11, "software shutdown");
    bus(1'b0, 8'h0c, 0);
    chk(rd[0], 1'b1, "enter status");
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0, "status cleared");
    bus(1'b1, 8'h10, 32'h0);
    pulse_wave();
    bus(1'b0, 8'h00, 0);
    chk(rd, ctl_read(1'b0, 8'h40), "auto restart");
    chk(irq, 1'b0, "masked irq");
    bus(1'b0, 8'h0c, 0);
    chk(rd[1], 1'b1, "release status");
    // Auto restart cannot clear while a source stays active
    bus(1'b1, 8'h00, 8'h44);
    trip <= 3'b100;
    pulse_wave();
    bus(1'b0, 8'h00, 0);
    chk(rd, ctl_read(1'b1, 8'h44), "source blocks restart");
    trip <= 3'b000;
    pulse_wave();
    bus(1'b0, 8'h00, 0);
    chk(rd, ctl_read(1'b0, 8'h44), "restart after source");
    bus(1'b0, 8'h20, 0);
    chk(rd, 0, "unmapped read");
    // Dead-band counts: random rise count, fall count of two
    band = $random(seed);
    band[5:3] = 3'b000;
    bus(1'b1, 8'h04, band);
    bus(1'b0, 8'h04, 0);
    chk(rd, {26'h0, band[5:0]}, "rise count");
    wb_sel_i <= 4'he;
    bus(1'b1, 8'h04, 32'h3f);
    wb_sel_i <= 4'hf;
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b0, 8'h04, 0);
    chk(rd, {26'h0, band[5:0]}, "lane 0 off");
    wave_in <= 1'b1;
    for (j = 0; j < 12; j++) begin
      @(negedge clk_sys);
      chk({out_a, out_b}, {db_on(j, band[5:0]), j < 2}, "band rise");
    end
    @(posedge clk_sys);
    wave_in <= 1'b0;
    for (j = 0; j < 8; j++) begin
      @(negedge clk_sys);
      chk({out_a, out_b}, {j < 2, db_on(j, 2)}, "band fall");
    end
    @(posedge clk_sys);
    bus(1'b0, 8'h14, 0);
    chk(rd, 32'h04, "gen status");
    // Every source and the software set have been seen by now
    bus(1'b0, 8'h18, 0);
    chk(rd, 32'hf, "cause record");
    bus(1'b1, 8'h18, 32'hf);
    bus(1'b0, 8'h18, 0);
    chk(rd, 0, "cause cleared");
    // Reset in mid-run returns the registers to their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 8'h00, 0);
    chk(rd, 0, "control after reset");
    bus(1'b0, 8'h04, 0);
    chk(rd, 0, "rise count after reset");
    tally_and_finish();
  end
endmodule // waveform_auto_shutdown_tb_top

/* hw/dead_band_delay.v */
// Delays the rising edge of one output by a programmed count of cycles
`include "shutdown_regs.vh"
module dead_band_delay (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Edge marks and delay
  input wire start_pulse,
  input wire stop_pulse,
  input wire [`DEAD_BAND_WIDTH-1:0] delay,
  // Delayed level
  output reg drive
);

  reg [`DEAD_BAND_WIDTH-1:0] count;
  reg busy;

  // ============================================================
  // Counter: falling edge cuts at once, rising edge waits delay cycles
  always @(posedge clk_sys) begin
    if (!rstn) begin
      count <= `DEAD_BAND_RESET;
      busy <= 1'b0;
      drive <= 1'b0;
    end else if (stop_pulse) begin
      busy <= 1'b0;
      drive <= 1'b0;
    end else if (start_pulse) begin
      count <= delay;
      busy <= (delay != `DEAD_BAND_RESET);
      drive <= (delay == `DEAD_BAND_RESET);
    end else if (busy) begin
      if (count == 6'h01) begin
        busy <= 1'b0;
        drive <= 1'b1; // Uncertain by one cycle from sampling
      end
      count <= count - 6'h01;
    end
  end

endmodule // dead_band_delay

/* hw/input_edge_detect.v */
// Registers the generator input and marks its rising and falling edges
module input_edge_detect (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Generator input and edge marks
  input wire wave_in,
  output reg wave_q,
  output wire rise_pulse,
  output wire fall_pulse
);

  reg wave_prev;

  // ============================================================
  // Sample stage; an asynchronous edge lands on the next clock
  always @(posedge clk_sys) begin
    if (!rstn) begin
      wave_q <= 1'b0;
      wave_prev <= 1'b0;
    end else begin
      wave_q <= wave_in;
      wave_prev <= wave_q;
    end
  end

  // Edge marks, one cycle each
  assign rise_pulse = wave_q & ~wave_prev;
  assign fall_pulse = ~wave_q & wave_prev;

endmodule // input_edge_detect

/* hw/shutdown_regs.vh */
// Register offsets, field positions, reset values and widths for shutdown
`ifndef SHUTDOWN_REGS_VH
`define SHUTDOWN_REGS_VH

// ============================================================
// Byte offsets on the register bus
`define OFS_SHUTDOWN_CONTROL 8'h00
`define OFS_DEAD_BAND_RISE 8'h04
`define OFS_DEAD_BAND_FALL 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10
`define OFS_GEN_STATUS 8'h14
`define OFS_SHUTDOWN_CAUSE 8'h18

// ============================================================
// Fields of shutdown_control
`define BIT_SHUTDOWN_EVENT_FLAG 7
`define BIT_AUTO_RESTART_ENABLE 6
`define BIT_SHUTDOWN_ON_COMPARATOR_EN 2
`define BIT_SHUTDOWN_ON_FAULT_PIN_EN 1
`define BIT_SHUTDOWN_ON_LOGIC_CELL_EN 0
`define SHUTDOWN_CONTROL_WMASK 8'hc7
`define SHUTDOWN_CONTROL_RESET 8'h00

// ============================================================
// Dead-band counters
`define DEAD_BAND_WIDTH 6
`define DEAD_BAND_RESET 6'h00

// ============================================================
// Interrupt status and mask bits
`define IRQ_WIDTH 2
`define IRQ_BIT_SHUTDOWN_ENTER 0
`define IRQ_BIT_RESTART 1
`define IRQ_RESET 2'h0

// ============================================================
// Cause bits, same order as the source enables
`define CAUSE_WIDTH 4
`define CAUSE_BIT_LOGIC_CELL 0
`define CAUSE_BIT_FAULT_PIN 1
`define CAUSE_BIT_COMPARATOR 2
`define CAUSE_BIT_SOFTWARE 3
`define CAUSE_RESET 4'h0

`endif

/* hw/waveform_auto_shutdown.v */
// Auto-shutdown and dead-band control for the complementary waveform gen
//
// Notes on behaviour
// - Dead-band delay may be off by one clock for asynchronous input edges.
// - Setting the event flag by software forces the override levels.
// - Without auto-restart, shutdown lasts until software clears the flag.
// - Auto-restart clears the flag on an input rise when no source is on.
// - An enabled active source forces the override levels at once.
// - Any mix of sources may be enabled; any one active causes shutdown.
// - Sources are levels; an enabled active source blocks any clearing.
// - The event flag reads 1 after a shutdown event, else 0.
// - The auto-restart bit picks automatic restart (1) or held shutdown (0).
// - High comparator output shuts down when enabled, else is ignored.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "shutdown_regs.vh"
module waveform_auto_shutdown (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Generator input and override levels
  input wire wave_in,
  input wire override_level_a,
  input wire override_level_b,
  // Shutdown sources
  input wire comparator_async_out,
  input wire logic_cell_two_out,
  input wire fault_input_pin_n,
  // Driven outputs and interrupt
  output wire out_a,
  output wire out_b,
  output reg irq
);

  // ============================================================
  // Register state
  reg shutdown_event_flag;
  reg auto_restart_enable;
  reg shutdown_on_comparator_en;
  reg shutdown_on_fault_pin_en;
  reg shutdown_on_logic_cell_en;
  reg [`DEAD_BAND_WIDTH-1:0] dead_band_rise;
  reg [`DEAD_BAND_WIDTH-1:0] dead_band_fall;
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;
  reg [`CAUSE_WIDTH-1:0] shutdown_cause;
  reg shutdown_prev;

  // Bus decode
  wire bus_req;
  wire wr_en;
  wire rd_en;
  wire wr_lane0;
  reg [31:0] next_rdata;

  // Generator datapath
  wire wave_q;
  wire wave_rise;
  wire wave_fall;
  wire drive_a;
  wire drive_b;
  wire comp_hit;
  wire fault_hit;
  wire cell_hit;
  wire source_active;
  wire shutdown_active;
  wire sw_flag_write;
  wire sw_flag_value;
  reg next_flag;
  reg [`IRQ_WIDTH-1:0] irq_events;
  reg [`IRQ_WIDTH-1:0] next_irq_status;
  reg [`CAUSE_WIDTH-1:0] next_cause;

  // ============================================================
  // Offset match, shared by write and read decode
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  // ============================================================
  // Bus handshake: one request, ack one cycle later, dropped after
  // The ack is registered, so each access spans two edges; masking the
  // request with ack keeps a master that still holds stb in the ack
  // cycle from being taken a second time
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i;
  assign rd_en = bus_req & ~wb_we_i;
  assign wr_lane0 = wr_en & wb_sel_i[0];

  always @(posedge clk_sys) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // ============================================================
  // Input sampling and dead-band engines
  input_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wave_in(wave_in),
    .wave_q(wave_q),
    .rise_pulse(wave_rise),
    .fall_pulse(wave_fall)
  );

  // The edge marks come in the same cycle as the registered input and the
  // drive flop adds one clock, so an output rises two clocks plus its count
  // after the input; an input edge between clocks adds up to one more clock of delay
  // Output A follows the input, its rise held back by the rise count
  dead_band_delay u_band_a (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start_pulse(wave_rise),
    .stop_pulse(wave_fall),
    .delay(dead_band_rise),
    .drive(drive_a)
  );

  // Output B is the complement, its rise held back by the fall count
  dead_band_delay u_band_b (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start_pulse(wave_fall),
    .stop_pulse(wave_rise),
    .delay(dead_band_fall),
    .drive(drive_b)
  );

  // ============================================================
  // The fault pin is active low, the comparator and logic cell active
  // high; a source counts only while its enable bit is set
  // Source qualification; purely combinational so that a fault
  // reaches the pins without waiting for the clock
  assign comp_hit = shutdown_on_comparator_en & comparator_async_out;
  assign fault_hit = shutdown_on_fault_pin_en & ~fault_input_pin_n;
  assign cell_hit = shutdown_on_logic_cell_en & logic_cell_two_out;
  assign source_active = comp_hit | fault_hit | cell_hit;
  assign shutdown_active = shutdown_event_flag | source_active;

  // Override mux; the only outputs not taken straight from a flop,
  // since waiting a clock would let a fault through
  assign out_a = shutdown_active ? override_level_a : drive_a;
  assign out_b = shutdown_active ? override_level_b : drive_b;

  // ============================================================
  // Event flag next value
  assign sw_flag_write = wr_lane0 & hit(wb_adr_i, `OFS_SHUTDOWN_CONTROL);
  assign sw_flag_value = wb_dat_i[`BIT_SHUTDOWN_EVENT_FLAG];

  // Priority of the flag: an active source beats everything, so neither
  // a software clear nor an input rise can end a shutdown while a fault
  // stands; a software write may clear the flag at any time once the
  // sources are quiet, with auto-restart on or off
  always @* begin
    next_flag = shutdown_event_flag;
    if (source_active) begin
      next_flag = 1'b1; // Set wins over any clear
    end else if (sw_flag_write) begin
      next_flag = sw_flag_value;
    end else if (auto_restart_enable && wave_rise) begin
      next_flag = 1'b0; // Self clear on the input rise
    end
  end

  // ============================================================
  // Control register and dead-band counts
  // Only lane 0 carries register bits; a write with sel[0] low is
  // acknowledged and otherwise ignored
  always @(posedge clk_sys) begin
    if (!rstn) begin
      shutdown_event_flag <= 1'b0;
      auto_restart_enable <= 1'b0;
      shutdown_on_comparator_en <= 1'b0;
      shutdown_on_fault_pin_en <= 1'b0;
      shutdown_on_logic_cell_en <= 1'b0;
      dead_band_rise <= `DEAD_BAND_RESET;
      dead_band_fall <= `DEAD_BAND_RESET;
      irq_mask <= `IRQ_RESET;
    end else begin
      shutdown_event_flag <= next_flag;
      if (sw_flag_write) begin
        auto_restart_enable <= wb_dat_i[`BIT_AUTO_RESTART_ENABLE];
        shutdown_on_comparator_en <=
          wb_dat_i[`BIT_SHUTDOWN_ON_COMPARATOR_EN];
        shutdown_on_fault_pin_en <= wb_dat_i[`BIT_SHUTDOWN_ON_FAULT_PIN_EN];
        shutdown_on_logic_cell_en <=
          wb_dat_i[`BIT_SHUTDOWN_ON_LOGIC_CELL_EN];
      end
      if (wr_lane0 && hit(wb_adr_i, `OFS_DEAD_BAND_RISE)) begin
        dead_band_rise <= wb_dat_i[`DEAD_BAND_WIDTH-1:0];
      end
      if (wr_lane0 && hit(wb_adr_i, `OFS_DEAD_BAND_FALL)) begin
        dead_band_fall <= wb_dat_i[`DEAD_BAND_WIDTH-1:0];
      end
      if (wr_lane0 && hit(wb_adr_i, `OFS_IRQ_MASK)) begin
        irq_mask <= wb_dat_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ============================================================
  // Interrupt events: entry into and release from shutdown
  // Status bits stay set until read; an event in the read cycle is kept
  // so that no change of the shutdown state is lost
  always @* begin
    irq_events = `IRQ_RESET;
    irq_events[`IRQ_BIT_SHUTDOWN_ENTER] = shutdown_active & ~shutdown_prev;
    irq_events[`IRQ_BIT_RESTART] = ~shutdown_active & shutdown_prev;
    next_irq_status = irq_status;
    if (rd_en && hit(wb_adr_i, `OFS_IRQ_STATUS)) begin
      next_irq_status = `IRQ_RESET;
    end
    // A new event in the read cycle survives the clear
    next_irq_status = next_irq_status | irq_events;
  end

  // Cause record: which sources held the shutdown, write 1 to clear
  // A clear and a new hit in one cycle leave the bit set, so a source
  // that is still active can never be wiped from the record
  always @* begin
    next_cause = shutdown_cause;
    if (wr_lane0 && hit(wb_adr_i, `OFS_SHUTDOWN_CAUSE)) begin
      next_cause = shutdown_cause & ~wb_dat_i[`CAUSE_WIDTH-1:0];
    end
    next_cause[`CAUSE_BIT_LOGIC_CELL] =
      next_cause[`CAUSE_BIT_LOGIC_CELL] | cell_hit;
    next_cause[`CAUSE_BIT_FAULT_PIN] =
      next_cause[`CAUSE_BIT_FAULT_PIN] | fault_hit;
    next_cause[`CAUSE_BIT_COMPARATOR] =
      next_cause[`CAUSE_BIT_COMPARATOR] | comp_hit;
    next_cause[`CAUSE_BIT_SOFTWARE] = next_cause[`CAUSE_BIT_SOFTWARE] |
      (sw_flag_write & sw_flag_value);
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      irq_status <= `IRQ_RESET;
      shutdown_cause <= `CAUSE_RESET;
      shutdown_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      shutdown_cause <= next_cause;
      shutdown_prev <= shutdown_active;
      irq <= |(next_irq_status & irq_mask); // Level, registered
    end
  end

  // ============================================================
  // Read multiplexer; unmapped offsets read zero
  always @* begin
    next_rdata = 32'h00000000;
    if (hit(wb_adr_i, `OFS_SHUTDOWN_CONTROL)) begin
      next_rdata[`BIT_SHUTDOWN_EVENT_FLAG] = shutdown_event_flag;
      next_rdata[`BIT_AUTO_RESTART_ENABLE] = auto_restart_enable;
      next_rdata[`BIT_SHUTDOWN_ON_COMPARATOR_EN] = shutdown_on_comparator_en;
      next_rdata[`BIT_SHUTDOWN_ON_FAULT_PIN_EN] = shutdown_on_fault_pin_en;
      next_rdata[`BIT_SHUTDOWN_ON_LOGIC_CELL_EN] = shutdown_on_logic_cell_en;
      // Bits 5..3 stay zero and have no storage
    end else if (hit(wb_adr_i, `OFS_DEAD_BAND_RISE)) begin
      next_rdata[`DEAD_BAND_WIDTH-1:0] = dead_band_rise;
    end else if (hit(wb_adr_i, `OFS_DEAD_BAND_FALL)) begin
      next_rdata[`DEAD_BAND_WIDTH-1:0] = dead_band_fall;
    end else if (hit(wb_adr_i, `OFS_IRQ_STATUS)) begin
      next_rdata[`IRQ_WIDTH-1:0] = irq_status;
    end else if (hit(wb_adr_i, `OFS_IRQ_MASK)) begin
      next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
    end else if (hit(wb_adr_i, `OFS_GEN_STATUS)) begin
      next_rdata[5:0] = {wave_q, source_active, shutdown_active,
        drive_b, drive_a, irq};
    end else if (hit(wb_adr_i, `OFS_SHUTDOWN_CAUSE)) begin
      next_rdata[`CAUSE_WIDTH-1:0] = shutdown_cause;
    end
  end

  // Read data registered with the ack, zero outside a read
  // Zero outside the ack cycle keeps stale data off the bus and makes a
  // late or doubled ack easy to spot
  always @(posedge clk_sys) begin
    if (!rstn) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_en) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end

endmodule // waveform_auto_shutdown
